// *** rtl/ocu_pkg.sv ***
// Purpose: shared constants for the 8-bit timer output compare unit
// Assumes: one system clock, timer clock enable pulse from the prescaler
// Notes: register offsets are word indices on the plain register port
package ocu_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] count_addr = 4'h0; // timer_count_value
  localparam logic [3:0] compare_addr = 4'h1; // compare_value_register
  localparam logic [3:0] control_addr = 4'h2; // mode, action, force
  localparam logic [3:0] status_addr = 4'h3; // flag and output state
  localparam logic [3:0] irq_addr = 4'h4; // irq enable

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int mode_lsb = 0; // waveform_mode_select [1:0]
  localparam int action_lsb = 2; // output_action_select [3:2]
  localparam int force_bit = 7; // force_compare_strobe
  localparam int flag_bit = 0; // compare_match_flag
  localparam int state_bit = 1; // compare_output_state
  localparam int irq_en_bit = 0; // compare_irq_enable

  // ----------------------------------------------------------------
  // reset values and extremes
  // ----------------------------------------------------------------
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [1:0] field_reset = 2'b00; // mode and action fields
  localparam logic [7:0] bottom_value = 8'h00;
  localparam logic [7:0] max_value = 8'hff;

  // ----------------------------------------------------------------
  // waveform modes (1 is the unbuilt phase correct pwm)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_normal = 2'b00,
    mode_phase_pwm = 2'b01,
    mode_clear_on_match = 2'b10,
    mode_fast_pwm = 2'b11
  } wave_mode_t;

endpackage : ocu_pkg

// *** rtl/timer8_output_compare_unit.sv ***
// Purpose: output compare and compare-match output logic of an 8-bit timer
// Assumes: counter lives outside; count and top arrive each cycle
// Notes: register port answers reads one cycle later; no wait states
`timescale 1ns/1ps
module timer8_output_compare_unit (
  input wire logic ref_clk_i, // 200 MHz system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic clk_en_i, // freezes all state while low
  input wire logic timer_tick_i, // timer clock enable pulse
  input wire logic [7:0] count_i, // timer_count_value from counter
  input wire logic count_at_top_i, // counter is at its top value
  input wire logic global_irq_en_i, // global enable of cpu_status_register
  input wire logic irq_ack_i, // interrupt being serviced
  input wire logic port_data_i, // general port value for the pin
  input wire logic [3:0] addr_i, // register word index
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  output logic compare_irq_o, // compare interrupt request
  output logic compare_output_state_o, // internal output state bit
  output logic pin_o, // value to the pin
  output logic pin_from_compare_o, // pin driven by output state
  output logic count_write_o, // pulse: cpu wrote the count
  output logic [7:0] count_wdata_o, // the count value written
  output logic match_o, // registered match, pre-blocking
  output logic at_bottom_o, // count at bottom
  output logic at_max_o // count at max
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] active_cmp_reg; // compare value the comparator uses
  logic [7:0] buffer_cmp_reg; // pwm buffer for the compare value
  logic [1:0] mode_reg; // waveform_mode_select
  logic [1:0] action_reg; // output_action_select
  logic irq_en_reg; // compare_irq_enable
  logic flag_reg; // compare_match_flag
  logic state_reg; // compare_output_state
  logic block_reg; // count write blocks the next tick's match
  logic pending_reg; // match waiting to set the flag
  logic force_reg; // forced match waiting for the waveform logic

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // pwm modes are 01 and 11: the low mode bit is set
  function automatic logic is_pwm(input logic [1:0] m);
    is_pwm = (m == ocu_pkg::mode_phase_pwm) || (m == ocu_pkg::mode_fast_pwm);
  endfunction : is_pwm

  // next output state for a match under mode and action
  function automatic logic match_state(input logic [1:0] m, input logic [1:0] a, input logic cur);
    case ({is_pwm(m), a})
      3'b001: match_state = ~cur; // toggle, non-pwm only
      3'b010, 3'b110: match_state = 1'b0; // clear, non-inverting pwm
      3'b011, 3'b111: match_state = 1'b1; // set, inverting pwm
      default: match_state = cur; // disconnected, or pwm action 1
    endcase
  endfunction : match_state

  logic pwm_mode; // double buffering active
  logic equal; // comparator output
  logic cpu_cmp_wr; // cpu writes the compare value
  logic count_wr; // cpu writes the count
  logic real_match; // unblocked match on this tick
  logic at_bottom; // count at bottom
  logic at_max; // count at max

  assign pwm_mode = is_pwm(mode_reg);
  assign equal = (count_i == active_cmp_reg);
  assign at_bottom = (count_i == ocu_pkg::bottom_value);
  assign at_max = (count_i == ocu_pkg::max_value);
  assign cpu_cmp_wr = wr_i && (addr_i == ocu_pkg::compare_addr);
  assign count_wr = wr_i && (addr_i == ocu_pkg::count_addr);
  // the block covers the first tick after the write, stopped or not
  assign real_match = timer_tick_i && equal && !block_reg;

  // ----------------------------------------------------------------
  // compare value registers
  // ----------------------------------------------------------------
  // buffered writes land in the buffer, direct ones in the active value
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      active_cmp_reg <= ocu_pkg::byte_reset;
      buffer_cmp_reg <= ocu_pkg::byte_reset;
    end
    else if (clk_en_i)
    begin
      if (cpu_cmp_wr)
      begin
        buffer_cmp_reg <= wdata_i;
      end
      if (cpu_cmp_wr && !pwm_mode)
      begin
        active_cmp_reg <= wdata_i; // immediate update
      end
      else if (pwm_mode && timer_tick_i && (count_at_top_i || at_bottom))
      begin
        active_cmp_reg <= buffer_cmp_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // action bits are written straight through: no buffering
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_reg <= ocu_pkg::field_reset;
      action_reg <= ocu_pkg::field_reset;
      irq_en_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (wr_i && (addr_i == ocu_pkg::control_addr))
      begin
        mode_reg <= wdata_i[ocu_pkg::mode_lsb +: 2];
        action_reg <= wdata_i[ocu_pkg::action_lsb +: 2];
      end
      if (wr_i && (addr_i == ocu_pkg::irq_addr))
      begin
        irq_en_reg <= wdata_i[ocu_pkg::irq_en_bit];
      end
    end
  end

  // ----------------------------------------------------------------
  // force strobe and match blocking
  // ----------------------------------------------------------------
  // force ignored in pwm modes; block held until the next tick
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      force_reg <= 1'b0;
      block_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      force_reg <= wr_i && (addr_i == ocu_pkg::control_addr)
                   && wdata_i[ocu_pkg::force_bit] && !pwm_mode;
      // a count write arms the block; the next tick spends it, stopped timer or not
      block_reg <= count_wr || (block_reg && !timer_tick_i);
    end
  end

  // ----------------------------------------------------------------
  // match flag
  // ----------------------------------------------------------------
  // set wins over a same-cycle clear so no match is lost
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pending_reg <= 1'b0;
      flag_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (real_match)
      begin
        pending_reg <= 1'b1;
      end
      else if (timer_tick_i)
      begin
        pending_reg <= 1'b0;
      end
      if (timer_tick_i && pending_reg)
      begin
        flag_reg <= 1'b1; // next timer tick
      end
      else if (irq_ack_i)
      begin
        flag_reg <= 1'b0;
      end
      else if (wr_i && (addr_i == ocu_pkg::status_addr) && wdata_i[ocu_pkg::flag_bit])
      begin
        flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // waveform generator
  // ----------------------------------------------------------------
  // mode change alone never touches the state bit
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (real_match || force_reg)
      begin
        state_reg <= match_state(mode_reg, action_reg, state_reg);
      end
      else if (timer_tick_i && (mode_reg == ocu_pkg::mode_fast_pwm) && at_max && action_reg[1])
      begin
        // count wraps to bottom next tick: action 2 sets, action 3 clears
        state_reg <= ~action_reg[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      compare_irq_o <= 1'b0;
      compare_output_state_o <= 1'b0;
      pin_o <= 1'b0;
      pin_from_compare_o <= 1'b0;
      count_write_o <= 1'b0;
      count_wdata_o <= ocu_pkg::byte_reset;
      match_o <= 1'b0;
      at_bottom_o <= 1'b0;
      at_max_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      compare_irq_o <= flag_reg && irq_en_reg && global_irq_en_i;
      compare_output_state_o <= state_reg;
      pin_from_compare_o <= (action_reg != 2'b00);
      pin_o <= (action_reg != 2'b00) ? state_reg : port_data_i;
      count_write_o <= count_wr;
      count_wdata_o <= wdata_i;
      match_o <= equal;
      at_bottom_o <= at_bottom;
      at_max_o <= at_max;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= ocu_pkg::byte_reset;
    end
    else if (clk_en_i)
    begin
      rdata_o <= ocu_pkg::byte_reset;
      if (rd_i)
      begin
        case (addr_i)
          ocu_pkg::count_addr: rdata_o <= count_i;
          ocu_pkg::compare_addr: rdata_o <= pwm_mode ? buffer_cmp_reg : active_cmp_reg;
          ocu_pkg::control_addr: rdata_o <= {4'h0, action_reg, mode_reg};
          ocu_pkg::status_addr: rdata_o <= {6'h00, state_reg, flag_reg};
          ocu_pkg::irq_addr: rdata_o <= {7'h00, irq_en_reg};
          default: rdata_o <= ocu_pkg::byte_reset; // unmapped reads zero
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_flag_late;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && real_match && !pending_reg && !flag_reg) |=> !flag_reg;
  endproperty
  a_flag_late: assert property (p_flag_late) else $error("flag set in match cycle");

  property p_irq;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i |=> (compare_irq_o == $past(flag_reg && irq_en_reg && global_irq_en_i));
  endproperty
  a_irq: assert property (p_irq) else $error("irq request wrong");

  property p_ack_clear;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && irq_ack_i && !(timer_tick_i && pending_reg)) |=> !flag_reg;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear flag");

  property p_sw_clear;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && wr_i && addr_i == ocu_pkg::status_addr && !wdata_i[ocu_pkg::flag_bit]
      && !irq_ack_i && flag_reg) |=> flag_reg;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("zero write cleared flag");

  property p_direct;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && cpu_cmp_wr && !pwm_mode) |=> (active_cmp_reg == $past(wdata_i));
  endproperty
  a_direct: assert property (p_direct) else $error("direct write lost");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && pwm_mode && !(timer_tick_i && (count_at_top_i || at_bottom))) |=> $stable(active_cmp_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("buffer moved off top/bottom");

  sequence s_count_write;
    clk_en_i && count_wr;
  endsequence
  property p_block;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_count_write |=> block_reg;
  endproperty
  a_block: assert property (p_block) else $error("match block not armed");

  property p_block_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && block_reg && !timer_tick_i) |=> block_reg;
  endproperty
  a_block_hold: assert property (p_block_hold) else $error("match block dropped before a tick");

  property p_keep;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !real_match && !force_reg && !timer_tick_i) |=> $stable(state_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("output state moved");

  property p_toggle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (clk_en_i && real_match && mode_reg == ocu_pkg::mode_clear_on_match && action_reg == 2'b01)
      |=> (state_reg != $past(state_reg));
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on match");

endmodule : timer8_output_compare_unit

// *** dv/timer8_output_compare_unit_tb_top.sv ***
// Purpose: self-checking bench for the 8-bit timer output compare unit
// Assumes: bench plays counter, prescaler and cpu; register port has no wait states
// Notes: timer ticks are single-cycle pulses; the count changes on the tick edge
`timescale 1ns/1ps
module timer8_output_compare_unit_tb_top;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk_i = 1'b0; // 200 MHz
  logic reset_n_i = 1'b0; // held low at start
  logic clk_en_i = 1'b1; // dropped once to prove a frozen write
  logic timer_tick_i = 1'b0;
  logic count_at_top_i = 1'b0;
  logic global_irq_en_i = 1'b0;
  logic irq_ack_i = 1'b0;
  logic port_data_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] count_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] rdata_o;
  logic [7:0] count_wdata_o;
  logic compare_irq_o, compare_output_state_o, pin_o, pin_from_compare_o;
  logic count_write_o, match_o, at_bottom_o, at_max_o;
  int num_errors = 0; // mismatches
  int cmp_count = 0; // comparisons made
  logic [1:0] acts [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3}; // force actions in order
  logic [7:0] sts [5] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h02}; // status after each force

  always #2.5 ref_clk_i = ~ref_clk_i;

  timer8_output_compare_unit timer8_output_compare_unit_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .timer_tick_i(timer_tick_i), .count_i(count_i), .count_at_top_i(count_at_top_i),
    .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i), .port_data_i(port_data_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .compare_irq_o(compare_irq_o), .compare_output_state_o(compare_output_state_o),
    .pin_o(pin_o), .pin_from_compare_o(pin_from_compare_o), .count_write_o(count_write_o),
    .count_wdata_o(count_wdata_o), .match_o(match_o), .at_bottom_o(at_bottom_o), .at_max_o(at_max_o)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one comparison, counted; x never matches
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // single-cycle write strobe
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    check(what, rdata_o, exp);
  endtask : rchk

  // one timer tick with the counter showing c
  task tk(input logic [7:0] c);
    @(posedge ref_clk_i);
    count_i <= c;
    timer_tick_i <= 1'b1;
    @(posedge ref_clk_i);
    timer_tick_i <= 1'b0;
  endtask : tk

  // let registered outputs settle
  task wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : wt

  function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] a, input logic f);
    ctl = 8'h00;
    ctl[ocu_pkg::mode_lsb +: 2] = m;
    ctl[ocu_pkg::action_lsb +: 2] = a;
    ctl[ocu_pkg::force_bit] = f;
  endfunction : ctl

  // single exit: counts, verdict, stop
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    #50000;
    num_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rchk("status", ocu_pkg::status_addr, 8'h00);
    wr(ocu_pkg::compare_addr, 8'h40);
    rchk("compare", ocu_pkg::compare_addr, 8'h40);
    tk(8'h40);
    wt(2);
    check("match", 8'(match_o), 8'h01);
    rchk("flag early", ocu_pkg::status_addr, 8'h00);
    tk(8'h10);
    rchk("flag set", ocu_pkg::status_addr, 8'h01);
    // interrupt gating then service
    wr(ocu_pkg::irq_addr, 8'h01);
    wt(3);
    check("irq no global", 8'(compare_irq_o), 8'h00);
    @(posedge ref_clk_i);
    global_irq_en_i <= 1'b1;
    wt(3);
    check("irq", 8'(compare_irq_o), 8'h01);
    @(posedge ref_clk_i);
    irq_ack_i <= 1'b1;
    @(posedge ref_clk_i);
    irq_ack_i <= 1'b0;
    wt(3);
    check("irq serviced", 8'(compare_irq_o), 8'h00);
    rchk("flag serviced", ocu_pkg::status_addr, 8'h00);
    // software clear: zero keeps, one clears
    tk(8'h40);
    tk(8'h10);
    wr(ocu_pkg::status_addr, 8'h00);
    rchk("flag kept", ocu_pkg::status_addr, 8'h01);
    wr(ocu_pkg::status_addr, 8'h01);
    rchk("flag cleared", ocu_pkg::status_addr, 8'h00);
    // count write hides the match on the next tick
    // written value differs from compare and is not bottom; counter counts up
    wr(ocu_pkg::count_addr, 8'h3f);
    #1;
    check("count write", 8'(count_write_o), 8'h01);
    check("count data", count_wdata_o, 8'h3f);
    tk(8'h40);
    tk(8'h10);
    rchk("flag blocked", ocu_pkg::status_addr, 8'h00);
    rchk("count read", ocu_pkg::count_addr, 8'h10);
    // force strobe in normal mode: set, clear, toggle, toggle, set
    for (int i = 0; i < 5; i++)
    begin
      wr(ocu_pkg::control_addr, ctl(ocu_pkg::mode_normal, acts[i], 1'b1));
      rchk("forced state", ocu_pkg::status_addr, sts[i]);
    end
    wt(2);
    check("state port", 8'(compare_output_state_o), 8'h01);
    check("pin src", 8'(pin_from_compare_o), 8'h01);
    check("pin", 8'(pin_o), 8'h01);
    // mode change keeps state, then toggle on a real match
    wr(ocu_pkg::control_addr, ctl(ocu_pkg::mode_clear_on_match, 2'h1, 1'b0));
    rchk("state kept", ocu_pkg::status_addr, 8'h02);
    tk(8'h40);
    tk(8'h10);
    tk(8'h10);
    rchk("toggled", ocu_pkg::status_addr, 8'h01);
    wr(ocu_pkg::status_addr, 8'h01);
    // action zero hands the pin to the port at once
    wr(ocu_pkg::control_addr, ctl(ocu_pkg::mode_normal, 2'h0, 1'b0));
    port_data_i <= 1'b1;
    wt(3);
    check("pin src off", 8'(pin_from_compare_o), 8'h00);
    check("pin port", 8'(pin_o), 8'h01);
    // fast pwm: buffered compare, clear on match, set at max
    wr(ocu_pkg::control_addr, ctl(ocu_pkg::mode_fast_pwm, 2'h2, 1'b0));
    wr(ocu_pkg::compare_addr, 8'h80);
    rchk("buffer", ocu_pkg::compare_addr, 8'h80);
    tk(8'h80);
    tk(8'h10);
    rchk("not yet active", ocu_pkg::status_addr, 8'h00);
    tk(8'hff);
    tk(8'h10);
    rchk("set at max", ocu_pkg::status_addr, 8'h02);
    tk(8'h00);
    tk(8'h80);
    tk(8'h10);
    rchk("pwm match", ocu_pkg::status_addr, 8'h01);
    // second copy through the top indication
    wr(ocu_pkg::status_addr, 8'h01);
    wr(ocu_pkg::compare_addr, 8'h20);
    count_at_top_i <= 1'b1;
    tk(8'h10);
    count_at_top_i <= 1'b0;
    tk(8'h20);
    tk(8'h10);
    rchk("top copy", ocu_pkg::status_addr, 8'h01);
    // force is ignored in pwm
    wr(ocu_pkg::control_addr, ctl(ocu_pkg::mode_fast_pwm, 2'h3, 1'b1));
    rchk("pwm force", ocu_pkg::status_addr, 8'h01);
    // phase pwm buffers too; leaving it shows the untouched active value
    wr(ocu_pkg::control_addr, ctl(ocu_pkg::mode_phase_pwm, 2'h0, 1'b0));
    wr(ocu_pkg::compare_addr, 8'h55);
    rchk("phase buffer", ocu_pkg::compare_addr, 8'h55);
    wr(ocu_pkg::control_addr, ctl(ocu_pkg::mode_normal, 2'h0, 1'b0));
    rchk("active kept", ocu_pkg::compare_addr, 8'h20);
    // extremes of the count
    @(posedge ref_clk_i);
    count_i <= 8'h00;
    wt(3);
    check("bottom", {6'h00, at_bottom_o, at_max_o}, 8'h02);
    @(posedge ref_clk_i);
    count_i <= 8'hff;
    wt(3);
    check("max", {6'h00, at_bottom_o, at_max_o}, 8'h01);
    // frozen write, unmapped index
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    wr(ocu_pkg::irq_addr, 8'h00);
    clk_en_i <= 1'b1;
    rchk("frozen", ocu_pkg::irq_addr, 8'h01);
    rchk("unmapped", 4'hf, 8'h00);
    complete_run();
  end

endmodule : timer8_output_compare_unit_tb_top
